// ### shared/tca_pkg.sv
// constants and types of the transfer controller activation core
package tca_pkg;
  // ==================== sources ====================
  localparam int          NUM_SRC    = 8;
  localparam logic [6:0]  SRC_VEC [NUM_SRC] = '{7'h20, 7'h21, 7'h22, 7'h23,
                                                 7'h28, 7'h29, 7'h2C, 7'h2D};
  // ==================== memory map ====================
  localparam logic [23:0] VEC_BASE   = 24'h000400;
  localparam logic [7:0]  RAM_HI     = 8'hFF;
  localparam logic [23:0] DESC_BYTES = 24'h00000C;
  localparam logic [2:0]  DESC_LAST  = 3'h5;
  // ==================== register port ====================
  localparam logic [1:0]  OFS_SWVEC  = 2'h0;
  localparam logic [1:0]  OFS_SRCEN  = 2'h1;
  localparam logic [1:0]  OFS_STATUS = 2'h2;
  localparam logic [7:0]  RST_SWVEC  = 8'h00;
  localparam logic [7:0]  RST_SRCEN  = 8'h00;
  localparam int          SWEN_BIT   = 7;
  // ==================== descriptor mode fields ====================
  localparam int          MA_SM_LO   = 6;
  localparam int          MA_DM_LO   = 4;
  localparam int          MA_MD_LO   = 2;
  localparam int          MA_DTS_BIT = 1;
  localparam int          MA_SZ_BIT  = 0;
  localparam int          MB_CHN_BIT = 7;
  localparam int          MB_DIS_BIT = 6;
  localparam logic [1:0]  AM_INC     = 2'h2;
  localparam logic [1:0]  AM_DEC     = 2'h3;
  localparam logic [1:0]  MD_NORMAL  = 2'h0;
  localparam logic [1:0]  MD_REPEAT  = 2'h1;
  localparam logic [1:0]  MD_BLOCK   = 2'h2;
  // ==================== sequencer states ====================
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_VEC  = 7'h02,
    ST_DRD  = 7'h04,
    ST_RD   = 7'h08,
    ST_WR   = 7'h10,
    ST_WB   = 7'h20,
    ST_DONE = 7'h40
  } tca_state_t;
endpackage

// ### logic/tca_core.sv
// transfer controller activation core: arbitration, descriptors, moves
`timescale 1ns/100ps
module tca_core import tca_pkg::*; (
  input  wire logic               clk_i,       // 250 MHz clock
  input  wire logic               arst_n_i,    // async reset, active low
  input  wire logic [1:0]         reg_addr_i,  // register index
  input  wire logic [7:0]         reg_wdata_i, // register write data
  input  wire logic               reg_we_i,    // register write strobe
  input  wire logic               reg_re_i,    // register read strobe
  output logic      [7:0]         reg_rdata_o, // read data, next cycle
  input  wire logic [NUM_SRC-1:0] src_req_i,   // source request flags
  output logic      [NUM_SRC-1:0] cpu_irq_o,   // source irqs to cpu
  output logic      [NUM_SRC-1:0] flag_clr_o,  // clear source flag pulse
  output logic                    sw_irq_o,    // software end irq pulse
  output logic                    busy_o,      // activation in progress
  output logic                    mem_req_o,   // memory access request
  output logic                    mem_we_o,    // memory write
  output logic                    mem_word_o,  // 1 word, 0 byte
  output logic      [23:0]        mem_addr_o,  // memory byte address
  output logic      [15:0]        mem_wdata_o, // memory write data
  input  wire logic [15:0]        mem_rdata_i, // memory read data
  input  wire logic               mem_ack_i    // access done this cycle
);

  // ==================== state ====================
  tca_state_t            state_q;
  logic [7:0]            swvec_q;     // software_vector_register
  logic [NUM_SRC-1:0]    srcen_q;     // source_enable_bits
  logic                  sw_pend_q;
  logic                  act_sw_q;
  logic [2:0]            act_idx_q;
  logic [2:0]            widx_q;
  logic [23:0]           desc_q;
  logic [7:0]            mra_q;
  logic [23:0]           src_addr_q;  // source_address
  logic [7:0]            mrb_q;
  logic [23:0]           dst_addr_q;  // destination_address
  logic [15:0]           cra_q;
  logic [15:0]           crb_q;
  logic                  exp_q;
  logic                  done_fin;
  logic                  fin_keep;
  logic                  sw_win;
  logic                  hw_win;
  logic [2:0]            hw_idx;
  logic [NUM_SRC-1:0]    hw_pend;

  // ==================== helpers ====================
  // one address step of a unit
  function automatic logic [23:0] step_addr(input logic [23:0] a,
                                            input logic [1:0] m,
                                            input logic sz);
    logic [23:0] d;
    d = sz ? 24'h000002 : 24'h000001;
    if (m == AM_INC) begin
      step_addr = a + d;
    end else if (m == AM_DEC) begin
      step_addr = a - d;
    end else begin
      step_addr = a;
    end
  endfunction

  // undo the steps of a whole area of n units
  function automatic logic [23:0] undo_area(input logic [23:0] a,
                                            input logic [1:0] m,
                                            input logic sz,
                                            input logic [7:0] n);
    logic [23:0] d;
    d = (n == 8'h00) ? 24'h000100 : {16'h0000, n};
    if (sz) begin
      d = {d[22:0], 1'b0};
    end
    if (m == AM_INC) begin
      undo_area = a - d;
    end else if (m == AM_DEC) begin
      undo_area = a + d;
    end else begin
      undo_area = a;
    end
  endfunction

  // descriptor word for write back
  function automatic logic [15:0] wb_word(input logic [2:0] i,
                                          input logic [7:0] ma,
                                          input logic [23:0] sa,
                                          input logic [7:0] mb,
                                          input logic [23:0] da,
                                          input logic [15:0] ca,
                                          input logic [15:0] cb);
    unique case (i)
      3'h0:    wb_word = {ma, sa[23:16]};
      3'h1:    wb_word = sa[15:0];
      3'h2:    wb_word = {mb, da[23:16]};
      3'h3:    wb_word = da[15:0];
      3'h4:    wb_word = ca;
      default: wb_word = cb;
    endcase
  endfunction

  // ==================== arbitration ====================
  // enabled requests, mask free; held off while its flag clears
  assign hw_pend = src_req_i & srcen_q & ~flag_clr_o;
  assign sw_win  = sw_pend_q & swvec_q[SWEN_BIT];
  assign hw_win  = |hw_pend;

  // lowest index is lowest vector number and wins
  always_comb begin
    hw_idx = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (hw_pend[i]) begin
        hw_idx = i[2:0];
      end
    end
  end

  // completion after last descriptor; keep means select or expired
  assign done_fin = (state_q == ST_DONE) & ~mrb_q[MB_CHN_BIT];
  assign fin_keep = mrb_q[MB_DIS_BIT] | exp_q;

  // ==================== sequencer ====================
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q    <= ST_IDLE;
      act_sw_q   <= 1'b0;
      act_idx_q  <= 3'h0;
      widx_q     <= 3'h0;
      desc_q     <= 24'h000000;
      mra_q      <= 8'h00;
      src_addr_q <= 24'h000000;
      mrb_q      <= 8'h00;
      dst_addr_q <= 24'h000000;
      cra_q      <= 16'h0000;
      crb_q      <= 16'h0000;
      exp_q      <= 1'b0;
      mem_req_o  <= 1'b0;
      mem_we_o   <= 1'b0;
      mem_word_o <= 1'b0;
      mem_addr_o <= 24'h000000;
      mem_wdata_o <= 16'h0000;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          mem_we_o   <= 1'b0;
          mem_word_o <= 1'b1;
          if (sw_win) begin
            act_sw_q   <= 1'b1;
            mem_addr_o <= VEC_BASE + {16'h0000, swvec_q[6:0], 1'b0};
            mem_req_o  <= 1'b1;
            state_q    <= ST_VEC;
          end else if (hw_win) begin
            act_sw_q   <= 1'b0;
            act_idx_q  <= hw_idx;
            mem_addr_o <= VEC_BASE + {16'h0000, SRC_VEC[hw_idx], 1'b0};
            mem_req_o  <= 1'b1;
            state_q    <= ST_VEC;
          end
        end
        ST_VEC: begin
          if (mem_ack_i) begin
            desc_q     <= {RAM_HI, mem_rdata_i};
            mem_addr_o <= {RAM_HI, mem_rdata_i};
            widx_q     <= 3'h0;
            state_q    <= ST_DRD;
          end
        end
        ST_DRD: begin
          if (mem_ack_i) begin
            unique case (widx_q)
              3'h0: begin
                mra_q <= mem_rdata_i[15:8];
                src_addr_q[23:16] <= mem_rdata_i[7:0];
              end
              3'h1: src_addr_q[15:0] <= mem_rdata_i;
              3'h2: begin
                mrb_q <= mem_rdata_i[15:8];
                dst_addr_q[23:16] <= mem_rdata_i[7:0];
              end
              3'h3: dst_addr_q[15:0] <= mem_rdata_i;
              3'h4: cra_q <= mem_rdata_i;
              default: crb_q <= mem_rdata_i;
            endcase
            if (widx_q == DESC_LAST) begin
              mem_addr_o <= src_addr_q;
              mem_word_o <= mra_q[MA_SZ_BIT];
              state_q    <= ST_RD;
            end else begin
              mem_addr_o <= mem_addr_o + 24'h000002;
              widx_q     <= widx_q + 3'h1;
            end
          end
        end
        ST_RD: begin
          if (mem_ack_i) begin
            mem_wdata_o <= mem_rdata_i;
            mem_addr_o  <= dst_addr_q;
            mem_we_o    <= 1'b1;
            state_q     <= ST_WR;
          end
        end
        ST_WR: begin
          if (mem_ack_i) begin
            logic [23:0] ns;
            logic [23:0] nd;
            logic [7:0]  cl;
            logic        blk_more;
            ns = step_addr(src_addr_q, mra_q[MA_SM_LO +: 2], mra_q[MA_SZ_BIT]);
            nd = step_addr(dst_addr_q, mra_q[MA_DM_LO +: 2], mra_q[MA_SZ_BIT]);
            cl = cra_q[7:0] - 8'h01;
            blk_more = 1'b0;
            if (mra_q[MA_MD_LO +: 2] == MD_NORMAL) begin
              cra_q <= cra_q - 16'h0001;
              exp_q <= (cra_q == 16'h0001);
            end else begin
              if (cl == 8'h00) begin
                // area done: reload counter, restore area address
                cra_q[7:0] <= cra_q[15:8];
                if (mra_q[MA_DTS_BIT]) begin
                  ns = undo_area(ns, mra_q[MA_SM_LO +: 2],
                                 mra_q[MA_SZ_BIT], cra_q[15:8]);
                end else begin
                  nd = undo_area(nd, mra_q[MA_DM_LO +: 2],
                                 mra_q[MA_SZ_BIT], cra_q[15:8]);
                end
              end else begin
                cra_q[7:0] <= cl;
                blk_more   = (mra_q[MA_MD_LO +: 2] == MD_BLOCK);
              end
              if (mra_q[MA_MD_LO +: 2] == MD_BLOCK) begin
                if (cl == 8'h00) begin
                  crb_q <= crb_q - 16'h0001;
                end
                exp_q <= (cl == 8'h00) & (crb_q == 16'h0001);
              end else begin
                exp_q <= 1'b0;
              end
            end
            src_addr_q <= ns;
            dst_addr_q <= nd;
            if (blk_more) begin
              mem_addr_o <= ns;
              mem_we_o   <= 1'b0;
              state_q    <= ST_RD;
            end else begin
              mem_addr_o <= desc_q;
              mem_word_o <= 1'b1;
              widx_q     <= 3'h0;
              state_q    <= ST_WB;
            end
          end
        end
        ST_WB: begin
          if (mem_ack_i) begin
            if (widx_q == DESC_LAST) begin
              mem_req_o <= 1'b0;
              mem_we_o  <= 1'b0;
              state_q   <= ST_DONE;
            end else begin
              mem_addr_o <= mem_addr_o + 24'h000002;
              widx_q     <= widx_q + 3'h1;
            end
          end else begin
            mem_wdata_o <= wb_word(widx_q, mra_q, src_addr_q, mrb_q,
                                   dst_addr_q, cra_q, crb_q);
          end
        end
        ST_DONE: begin
          if (mrb_q[MB_CHN_BIT]) begin
            desc_q     <= desc_q + DESC_BYTES;
            mem_addr_o <= desc_q + DESC_BYTES;
            mem_req_o  <= 1'b1;
            mem_word_o <= 1'b1;
            widx_q     <= 3'h0;
            state_q    <= ST_DRD;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==================== software activation register ====================
  // enable bit is only set by software; vector locked while enabled
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      swvec_q   <= RST_SWVEC;
      sw_pend_q <= 1'b0;
    end else begin
      if (done_fin & act_sw_q & ~fin_keep) begin
        swvec_q[SWEN_BIT] <= 1'b0;
      end
      if ((state_q == ST_IDLE) & sw_win) begin
        sw_pend_q <= 1'b0;
      end
      // software write wins over the hardware clear
      if (reg_we_i & (reg_addr_i == OFS_SWVEC)) begin
        if (reg_wdata_i[SWEN_BIT]) begin
          swvec_q[SWEN_BIT] <= 1'b1;
          sw_pend_q         <= 1'b1;
        end
        if (~swvec_q[SWEN_BIT]) begin
          swvec_q[6:0] <= reg_wdata_i[6:0];
        end
      end
    end
  end

  // ==================== source enables ====================
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      srcen_q <= RST_SRCEN;
    end else if (reg_we_i & (reg_addr_i == OFS_SRCEN)) begin
      srcen_q <= reg_wdata_i;
    end else if (done_fin & ~act_sw_q & fin_keep) begin
      srcen_q[act_idx_q] <= 1'b0;
    end
  end

  // ==================== completion outputs ====================
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_clr_o <= '0;
      sw_irq_o   <= 1'b0;
    end else begin
      flag_clr_o <= '0;
      sw_irq_o   <= done_fin & act_sw_q & fin_keep;
      if (done_fin & ~act_sw_q & ~fin_keep) begin
        flag_clr_o[act_idx_q] <= 1'b1;
      end
    end
  end

  // per source: route to cpu while enable is clear
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_route
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          cpu_irq_o[g] <= 1'b0;
        end else begin
          cpu_irq_o[g] <= src_req_i[g] & ~srcen_q[g];
        end
      end
    end
  endgenerate

  // ==================== register read port ====================
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
      busy_o      <= 1'b0;
    end else begin
      busy_o <= (state_q != ST_IDLE);
      if (reg_re_i) begin
        unique case (reg_addr_i)
          OFS_SWVEC:  reg_rdata_o <= swvec_q;
          OFS_SRCEN:  reg_rdata_o <= srcen_q;
          OFS_STATUS: reg_rdata_o <= {3'h0, act_idx_q, act_sw_q,
                                      (state_q != ST_IDLE)};
          default:    reg_rdata_o <= 8'h00;
        endcase
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

endmodule // tca_core

// ### sim/tca_core_monitor.sv
// assertion checker bound to the activation core
`timescale 1ns/100ps
module tca_core_monitor import tca_pkg::*; (
  input wire logic               clk_i,       // clock
  input wire logic               arst_n_i,    // reset, active low
  input wire logic [NUM_SRC-1:0] src_req_i,   // source flags
  input wire logic [NUM_SRC-1:0] cpu_irq_o,   // irqs to cpu
  input wire logic [NUM_SRC-1:0] flag_clr_o,  // flag clear pulses
  input wire logic               sw_irq_o,    // software end irq
  input wire logic               mem_req_o,   // memory request
  input wire logic               mem_we_o,    // memory write
  input wire logic               mem_word_o,  // word access
  input wire logic [23:0]        mem_addr_o,  // memory address
  input wire logic [15:0]        mem_rdata_i, // memory read data
  input wire logic               mem_ack_i    // access done
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ==================== helper ====================
  logic first_q; // vector read next
  logic idle_q;  // bus idle last cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      first_q <= 1'b1;
      idle_q  <= 1'b1;
    end else begin
      first_q <= (!mem_req_o && idle_q) || (first_q && !mem_ack_i);
      idle_q  <= !mem_req_o;
    end
  end
  // ==================== properties ====================
  property p_irq_route;
    (cpu_irq_o & ~$past(src_req_i)) == 8'h00;
  endproperty
  a_irq_route: assert property (p_irq_route)
    else $error("cpu irq without flag");
  property p_req_hold;
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
      && $stable(mem_we_o) && $stable(mem_word_o);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request moved before ack");
  property p_vec_addr;
    mem_req_o && first_q |-> mem_addr_o[23:8] == 16'h0004
      && !mem_addr_o[0] && mem_word_o && !mem_we_o;
  endproperty
  a_vec_addr: assert property (p_vec_addr)
    else $error("bad vector read");
  property p_desc_addr;
    mem_req_o && first_q && mem_ack_i |=>
      mem_addr_o == {RAM_HI, $past(mem_rdata_i)} && !mem_we_o;
  endproperty
  a_desc_addr: assert property (p_desc_addr)
    else $error("bad descriptor address");
  property p_flag_pulse;
    flag_clr_o != 8'h00 |-> $onehot(flag_clr_o) ##1 flag_clr_o == 8'h00;
  endproperty
  a_flag_pulse: assert property (p_flag_pulse)
    else $error("bad flag clear pulse");
  property p_sw_pulse;
    sw_irq_o |=> !sw_irq_o && flag_clr_o == 8'h00;
  endproperty
  a_sw_pulse: assert property (p_sw_pulse)
    else $error("bad software irq pulse");
  property p_end_quiet;
    sw_irq_o || flag_clr_o != 8'h00 |->
      !$past(mem_req_o) && $past(mem_req_o, 2);
  endproperty
  a_end_quiet: assert property (p_end_quiet)
    else $error("completion pulse misplaced");
  property p_word_align;
    mem_req_o && mem_word_o |-> !mem_addr_o[0];
  endproperty
  a_word_align: assert property (p_word_align)
    else $error("word access at odd address");
endmodule // tca_core_monitor
bind tca_core tca_core_monitor tca_core_monitor_inst (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .src_req_i(src_req_i),
  .cpu_irq_o(cpu_irq_o), .flag_clr_o(flag_clr_o), .sw_irq_o(sw_irq_o),
  .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_word_o(mem_word_o),
  .mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata_i),
  .mem_ack_i(mem_ack_i));

// ### sim/tca_mem_model.sv
// memory bus and peripheral source flags facing the core
`timescale 1ns/100ps
module tca_mem_model import tca_pkg::*; (
  input  wire logic               clk_i,       // clock
  input  wire logic               arst_n_i,    // reset, active low
  input  wire logic               mem_req_i,   // access request
  input  wire logic               mem_we_i,    // write
  input  wire logic               mem_word_i,  // word access
  input  wire logic [23:0]        mem_addr_i,  // byte address
  input  wire logic [15:0]        mem_wdata_i, // write data
  output logic      [15:0]        mem_rdata_o, // read data
  output logic                    mem_ack_o,   // access done
  input  wire logic [1:0]         wait_i,      // extra wait cycles
  input  wire logic [NUM_SRC-1:0] src_set_i,   // raise flags
  input  wire logic [NUM_SRC-1:0] src_clr_i,   // software clear
  input  wire logic [NUM_SRC-1:0] flag_clr_i,  // core clear pulses
  output logic      [NUM_SRC-1:0] src_req_o    // source flags
);
  logic [7:0]  mem [bit [23:0]]; // sparse byte memory, big endian
  logic [24:0] key_q;
  logic [1:0]  cnt_q;
  logic [15:0] rd_q;
  logic        ack_q;
  logic        hit;
  // ack once the address has stood a cycle
  assign hit = mem_req_i && !ack_q && key_q == {mem_we_i, mem_addr_i};
  assign mem_ack_o = ack_q;
  // no stale data outside the ack cycle
  assign mem_rdata_o = ack_q ? rd_q : ~rd_q;
  // access engine with random wait states
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key_q <= 25'h0;
      cnt_q <= 2'h0;
      ack_q <= 1'b0;
      rd_q  <= 16'h0;
    end else begin
      key_q <= {mem_we_i, mem_addr_i};
      cnt_q <= hit ? cnt_q + 2'h1 : 2'h0;
      ack_q <= hit && cnt_q >= wait_i;
      if (hit && cnt_q >= wait_i && mem_we_i) begin
        if (mem_word_i) begin
          mem[mem_addr_i] = mem_wdata_i[15:8];
          mem[mem_addr_i + 24'h1] = mem_wdata_i[7:0];
        end else begin
          mem[mem_addr_i] = mem_wdata_i[7:0];
        end
      end else if (hit && cnt_q >= wait_i) begin
        rd_q <= mem_word_i ? {mem[mem_addr_i], mem[mem_addr_i + 24'h1]}
                           : {8'h00, mem[mem_addr_i]};
      end
    end
  end
  // source flags drop one cycle after a clear
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_req_o <= 8'h00;
    end else begin
      src_req_o <= (src_req_o | src_set_i) & ~flag_clr_i & ~src_clr_i;
    end
  end
endmodule // tca_mem_model

// ### sim/transfer_ctrl_activation_test.sv
// self-checking testbench of the activation core
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
  error_cnt++; $display("[FAIL] %0t got %0h want %0h", $time, a, b); end end
module transfer_ctrl_activation_test import tca_pkg::*;;
  logic               clk_i, arst_n_i, reg_we_i, reg_re_i, sw_irq_o;
  logic               busy_o, mem_req_o, mem_we_o, mem_word_o, mem_ack_i;
  logic [1:0]         reg_addr_i, wait_q;
  logic [7:0]         reg_wdata_i, reg_rdata_o, d, first_clr;
  logic [NUM_SRC-1:0] src_req, cpu_irq_o, flag_clr_o, src_set, src_clr;
  logic [23:0]        mem_addr_o;
  logic [15:0]        mem_wdata_o, mem_rdata_i, w;
  int                 error_cnt, tests_run, sw_cnt, clr_cnt, seed;
  tca_core tca_core_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .src_req_i(src_req), .cpu_irq_o(cpu_irq_o), .flag_clr_o(flag_clr_o),
    .sw_irq_o(sw_irq_o), .busy_o(busy_o), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_word_o(mem_word_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
    .mem_ack_i(mem_ack_i));
  tca_mem_model tca_mem_model_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_word_i(mem_word_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
    .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i), .wait_i(wait_q),
    .src_set_i(src_set), .src_clr_i(src_clr), .flag_clr_i(flag_clr_o),
    .src_req_o(src_req));
  // ==================== clock and capture ====================
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) wait_q <= 2'($random(seed));
  always @(negedge clk_i) begin
    if (sw_irq_o === 1'b1) sw_cnt++;
    if (flag_clr_o != 8'h00) begin
      if (clr_cnt == 0) first_clr = flag_clr_o;
      clr_cnt++;
    end
  end
  // ==================== tasks ====================
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic do_reset();
    arst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_we_i    <= 1'b1;
    @(posedge clk_i);
    reg_we_i    <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] v);
    reg_addr_i <= a;
    reg_re_i   <= 1'b1;
    @(posedge clk_i);
    reg_re_i   <= 1'b0;
    @(negedge clk_i);
    `CHK(reg_rdata_o, v);
    @(posedge clk_i);
  endtask
  task automatic pb(input logic [23:0] a, input logic [7:0] v);
    tca_mem_model_inst.mem[a] = v;
  endtask
  task automatic put_w(input logic [23:0] a, input logic [15:0] v);
    pb(a, v[15:8]);
    pb(a + 24'h1, v[7:0]);
  endtask
  function automatic logic [15:0] get_w(input logic [23:0] a);
    return {tca_mem_model_inst.mem[a], tca_mem_model_inst.mem[a + 24'h1]};
  endfunction
  // descriptor bases are multiples of four
  task automatic desc(input logic [23:0] b, input logic [7:0] ma,
    input logic [23:0] sa, input logic [7:0] mb, input logic [23:0] da,
    input logic [15:0] ca, input logic [15:0] cb);
    put_w(b, {ma, sa[23:16]});
    put_w(b + 24'h2, sa[15:0]);
    put_w(b + 24'h4, {mb, da[23:16]});
    put_w(b + 24'h6, da[15:0]);
    put_w(b + 24'h8, ca);
    put_w(b + 24'hA, cb);
  endtask
  task automatic vec(input logic [6:0] v, input logic [15:0] b);
    put_w(VEC_BASE + {16'h0000, v, 1'b0}, b);
  endtask
  task automatic raise(input logic [7:0] m);
    sw_cnt  = 0;
    clr_cnt = 0;
    src_set <= m;
    @(posedge clk_i);
    src_set <= 8'h00;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (busy_o !== 1'b1 && n < 50) begin @(negedge clk_i); n++; end
    while (busy_o !== 1'b0 && n < 2000) begin @(negedge clk_i); n++; end
    repeat (3) @(posedge clk_i);
    `CHK(n < 2000, 1'b1);
  endtask
  // ==================== watchdog ====================
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    complete_run();
  end
  // ==================== scenarios ====================
  initial begin
    {arst_n_i, reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i} = '0;
    {src_set, src_clr} = '0;
    seed = 43704;
    do_reset();
    rd(OFS_SWVEC, RST_SWVEC);
    rd(OFS_SRCEN, RST_SRCEN);
    rd(2'h3, 8'h00);
    $display("reset test done");
    // software start, byte, not expired
    d = 8'($random(seed));
    pb(24'h001000, d);
    vec(7'h10, 16'hFF00);
    desc(24'hFFFF00, 8'hB0, 24'h001000, 8'h00, 24'h002005, 16'h3, 16'h0);
    raise(8'h00);
    wr(OFS_SWVEC, 8'h90);
    wait_done();
    `CHK(tca_mem_model_inst.mem[24'h002005], d);
    `CHK(get_w(24'hFFFF02), 16'h1001);
    `CHK(get_w(24'hFFFF06), 16'h2004);
    `CHK(get_w(24'hFFFF08), 16'h0002);
    `CHK(sw_cnt, 0);
    rd(OFS_SWVEC, 8'h10);
    // software start, word, count runs out
    w = 16'($random(seed));
    put_w(24'h001010, w);
    vec(7'h11, 16'hFF10);
    desc(24'hFFFF10, 8'hA1, 24'h001010, 8'h00, 24'h002010, 16'h1, 16'h0);
    wr(OFS_SWVEC, 8'h91);
    wait_done();
    `CHK(get_w(24'h002010), w);
    `CHK(get_w(24'hFFFF12), 16'h1012);
    `CHK(sw_cnt, 1);
    wr(OFS_SWVEC, 8'h05);
    rd(OFS_SWVEC, 8'h91);
    rd(OFS_STATUS, 8'h02);
    $display("software test done");
    do_reset();
    // repeat mode, source 4, area on destination
    pb(24'h001020, d);
    vec(SRC_VEC[4], 16'hFF20);
    desc(24'hFFFF20, 8'h24, 24'h001020, 8'h00, 24'h002021, 16'h0201, 16'h0);
    wr(OFS_SRCEN, 8'h10);
    raise(8'h10);
    wait_done();
    `CHK(tca_mem_model_inst.mem[24'h002021], d);
    `CHK(get_w(24'hFFFF26), 16'h2020);
    `CHK(get_w(24'hFFFF28), 16'h0202);
    `CHK(clr_cnt, 1);
    `CHK(src_req[4], 1'b0);
    `CHK(cpu_irq_o, 8'h00);
    `CHK(sw_cnt, 0);
    rd(OFS_SRCEN, 8'h10);
    $display("repeat test done");
    // block of two, source 5, area on source, last
    pb(24'h001030, d);
    pb(24'h001031, ~d);
    vec(SRC_VEC[5], 16'hFF30);
    desc(24'hFFFF30, 8'hAA, 24'h001030, 8'h00, 24'h002030, 16'h0202, 16'h1);
    wr(OFS_SRCEN, 8'h20);
    raise(8'h20);
    wait_done();
    `CHK(tca_mem_model_inst.mem[24'h002031], ~d);
    `CHK(get_w(24'hFFFF32), 16'h1030);
    `CHK(get_w(24'hFFFF36), 16'h2032);
    `CHK(get_w(24'hFFFF3A), 16'h0000);
    `CHK(clr_cnt, 0);
    `CHK(src_req[5], 1'b1);
    `CHK(cpu_irq_o[5], 1'b1);
    rd(OFS_SRCEN, 8'h00);
    src_clr <= 8'h20;
    @(posedge clk_i);
    src_clr <= 8'h00;
    $display("block test done");
    // chain of two, first selects interrupt
    pb(24'h001040, d);
    pb(24'h001041, ~d);
    vec(SRC_VEC[1], 16'hFF40);
    desc(24'hFFFF40, 8'hA0, 24'h001040, 8'hC0, 24'h002040, 16'h5, 16'h0);
    desc(24'hFFFF4C, 8'hA0, 24'h001041, 8'h00, 24'h002048, 16'h5, 16'h0);
    wr(OFS_SRCEN, 8'h02);
    raise(8'h02);
    wait_done();
    `CHK(tca_mem_model_inst.mem[24'h002048], ~d);
    `CHK(tca_mem_model_inst.mem[24'h002040], d);
    `CHK(clr_cnt, 1);
    `CHK(cpu_irq_o, 8'h00);
    rd(OFS_SRCEN, 8'h02);
    $display("chain test done");
    // sources 0 and 2 together, source 3 left to the cpu
    for (int i = 0; i < 3; i += 2) begin
      vec(SRC_VEC[i], 16'hFF50 + 16'(i) * 16'h0010);
      desc(24'hFFFF50 + 24'(i) * 24'h10, 8'hA0, 24'h001050, 8'h00,
           24'h002050 + 24'(i), 16'h9, 16'h0);
    end
    pb(24'h001050, d);
    wr(OFS_SRCEN, 8'h05);
    raise(8'h0D);
    wait_done();
    wait_done();
    `CHK(first_clr, 8'h01);
    `CHK(clr_cnt, 2);
    `CHK(cpu_irq_o, 8'h08);
    $display("priority test done");
    complete_run();
  end
endmodule // transfer_ctrl_activation_test
